// *** rtl/mas_pkg.sv ***
// What this block does
// - one 16x16 or two 8x8 multipliers
// - one 32-bit or two 16-bit accumulators
// - adder split; result registered or combinational
// - input, intermediate, output registers each bypassable
// - product passes output then intermediate register
// - every slice register on one clock
// - clock enable low holds datapath registers except on clear
// - first, second operands feed multiplier or adder
// - third, fourth operands feed adder; third also feeds accumulator loads
// - each operand register has hold control
// - upper clear zeroes first, third, upper pipeline
// - lower clear zeroes second, fourth, lower, result
// - result word full or two split halves
// - upper accumulator hold keeps its value
// - upper accumulator clear zeroes high bits
// - upper load picks adder result or third
// - upper select adds or subtracts
// - lower accumulator hold keeps its value
// - lower accumulator clear zeroes low bits
// - slices chain into wider accumulators
// - lower load picks adder result or third
// - lower select adds or subtracts in split mode; joint adder follows upper select
// - cascade carry and sign in and out
package mas_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0]  CFG_OFS    = 8'h00; // static configuration
  localparam logic [7:0]  RES_OFS    = 8'h04; // result readback
  localparam logic [7:0]  CHAIN_OFS  = 8'h08; // chain outputs readback
  // ==========================================================
  // configuration bit positions
  localparam int CFG_SPLIT_MUL = 0;  // two 8x8 multipliers
  localparam int CFG_SPLIT_ACC = 1;  // two 16-bit adders
  localparam int CFG_REG_AB    = 2;  // first/second input regs used
  localparam int CFG_REG_CD    = 3;  // third/fourth input regs used
  localparam int CFG_REG_MUL   = 4;  // multiplier output reg used
  localparam int CFG_REG_MID   = 5;  // intermediate reg used
  localparam int CFG_REG_OHI   = 6;  // upper result registered
  localparam int CFG_REG_OLO   = 7;  // lower result registered
  localparam int CFG_DIR_HI    = 8;  // upper adder takes first op
  localparam int CFG_DIR_LO    = 9;  // lower adder takes second op
  localparam int CFG_FB_HI     = 10; // upper adder adds accumulator
  localparam int CFG_FB_LO     = 11; // lower adder adds accumulator
  localparam int CFG_W         = 12; // configuration width
  // ==========================================================
  // reset values
  localparam logic [11:0] CFG_RST    = 12'hcfc; // all regs, mac
  localparam logic [15:0] OPND_RST   = 16'h0000;
  localparam logic [31:0] WORD_RST   = 32'h0000_0000;
endpackage : mas_pkg

// *** rtl/mas_slice.sv ***
`timescale 1ns/1ps
`default_nettype none
module mas_slice
  import mas_pkg::*;
#(
  parameter int ADR_W = 8
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // slice clock enable
  input  wire logic              slice_clk_en_i,
  // operands
  input  wire logic [15:0]       op_first_i,
  input  wire logic [15:0]       op_second_i,
  input  wire logic [15:0]       op_third_i,
  input  wire logic [15:0]       op_fourth_i,
  // operand register holds
  input  wire logic              first_in_hold_port_i,
  input  wire logic              second_in_hold_port_i,
  input  wire logic              third_in_hold_port_i,
  input  wire logic              fourth_in_hold_port_i,
  // section clears
  input  wire logic              upper_input_clear_port_i,
  input  wire logic              lower_input_clear_port_i,
  // upper accumulator controls
  input  wire logic              upper_acc_hold_port_i,
  input  wire logic              upper_acc_clear_port_i,
  input  wire logic              upper_acc_load_port_i,
  input  wire logic              upper_add_sub_port_i,
  // lower accumulator controls
  input  wire logic              lower_acc_hold_port_i,
  input  wire logic              lower_acc_clear_port_i,
  input  wire logic              lower_acc_load_port_i,
  input  wire logic              lower_add_sub_port_i,
  // cascade
  input  wire logic              chain_carry_in_i,
  input  wire logic              chain_sign_in_i,
  output logic                   chain_carry_out_o,
  output logic                   chain_sign_out_o,
  // result
  output logic      [31:0]       result_o
);

  // ==========================================================
  // add or subtract with carry/borrow, 33-bit result
  function automatic logic [32:0] mas_addsub(
    input logic [31:0] y,
    input logic [31:0] x,
    input logic        xe,
    input logic        sub,
    input logic        ci
  );
    logic [32:0] ye;
    logic [32:0] xx;
    ye = {1'b0, y};
    xx = {xe, x};
    if (sub) begin
      mas_addsub = ye - xx - {32'h0000_0000, ci};
    end else begin
      mas_addsub = ye + xx + {32'h0000_0000, ci};
    end
  endfunction : mas_addsub

  // ==========================================================
  // state
  logic [CFG_W-1:0] cfg;          // static configuration
  logic [15:0]      a_q;          // first operand register
  logic [15:0]      b_q;          // second operand register
  logic [15:0]      c_q;          // third operand register
  logic [15:0]      d_q;          // fourth operand register
  logic [31:0]      mul_q;        // multiplier output register
  logic [31:0]      mid_q;        // intermediate register
  logic [15:0]      acc_hi;       // upper accumulator
  logic [15:0]      acc_lo;       // lower accumulator
  logic             carry_q;      // registered cascade carry
  logic             sign_q;       // registered cascade sign

  // ==========================================================
  // combinational datapath
  logic [15:0] a_v, b_v, c_v, d_v;  // operands after bypass
  logic [31:0] prod;                // raw product
  logic [31:0] mul_v;               // after multiplier out reg
  logic [31:0] mid_v;               // after intermediate reg
  logic [31:0] x_w, y_w;            // adder operands
  logic [32:0] sum32;               // joint 32-bit result
  logic [32:0] sum_h, sum_l;        // split 16-bit results
  logic [15:0] next_hi, next_lo;    // accumulator next values
  logic        next_carry;          // cascade carry next value

  // operand bypass selection
  assign a_v = cfg[CFG_REG_AB] ? a_q : op_first_i;
  assign b_v = cfg[CFG_REG_AB] ? b_q : op_second_i;
  assign c_v = cfg[CFG_REG_CD] ? c_q : op_third_i;
  assign d_v = cfg[CFG_REG_CD] ? d_q : op_fourth_i;

  // multiplier: full 16x16 or two independent 8x8
  always_comb begin
    if (cfg[CFG_SPLIT_MUL]) begin
      prod = {16'(a_v[15:8] * b_v[15:8]), 16'(a_v[7:0] * b_v[7:0])};
    end else begin
      prod = 32'(a_v * b_v);
    end
  end

  // product through output reg then intermediate reg
  assign mul_v = cfg[CFG_REG_MUL] ? mul_q : prod;
  assign mid_v = cfg[CFG_REG_MID] ? mid_q : mul_v;

  // adder operands: product or direct operand, plus
  // accumulator feedback or third/fourth operands
  always_comb begin
    x_w[31:16] = cfg[CFG_DIR_HI] ? a_v : mid_v[31:16];
    x_w[15:0]  = cfg[CFG_DIR_LO] ? b_v : mid_v[15:0];
    y_w[31:16] = cfg[CFG_FB_HI] ? acc_hi : c_v;
    y_w[15:0]  = cfg[CFG_FB_LO] ? acc_lo : d_v;
  end

  // joint adder: lower carry ripples into upper half
  assign sum32 = mas_addsub(y_w, x_w, chain_sign_in_i,
                            upper_add_sub_port_i, chain_carry_in_i);
  // split adders: no path between halves
  assign sum_l = mas_addsub({16'h0000, y_w[15:0]},
                            {16'h0000, x_w[15:0]}, 1'b0,
                            lower_add_sub_port_i, chain_carry_in_i);
  assign sum_h = mas_addsub({16'h0000, y_w[31:16]},
                            {16'h0000, x_w[31:16]}, 1'b0,
                            upper_add_sub_port_i, 1'b0);

  // accumulator next values with load selection
  always_comb begin
    if (cfg[CFG_SPLIT_ACC]) begin
      next_hi    = sum_h[15:0];
      next_lo    = sum_l[15:0];
      next_carry = sum_h[16];
    end else begin
      next_hi    = sum32[31:16];
      next_lo    = sum32[15:0];
      next_carry = sum32[32];
    end
    if (upper_acc_load_port_i) begin
      next_hi = c_v;
    end
    if (lower_acc_load_port_i) begin
      next_lo = c_v;
    end
  end

  // result: registered accumulator or combinational path
  assign result_o[31:16] = cfg[CFG_REG_OHI] ? acc_hi : next_hi;
  assign result_o[15:0]  = cfg[CFG_REG_OLO] ? acc_lo : next_lo;
  // cascade outputs follow the upper half register choice
  assign chain_carry_out_o = cfg[CFG_REG_OHI] ? carry_q
                                              : next_carry;
  assign chain_sign_out_o  = cfg[CFG_REG_OHI] ? sign_q
                                              : next_hi[15];

  // ==========================================================
  // operand registers: clear beats enable and hold
  always_ff @(posedge clk_i) begin
    if (rst_i || upper_input_clear_port_i) begin
      a_q <= OPND_RST;
      c_q <= OPND_RST;
    end else if (slice_clk_en_i) begin
      if (!first_in_hold_port_i) begin
        a_q <= op_first_i;
      end
      if (!third_in_hold_port_i) begin
        c_q <= op_third_i;
      end
    end
  end

  // lower operand registers
  always_ff @(posedge clk_i) begin
    if (rst_i || lower_input_clear_port_i) begin
      b_q <= OPND_RST;
      d_q <= OPND_RST;
    end else if (slice_clk_en_i) begin
      if (!second_in_hold_port_i) begin
        b_q <= op_second_i;
      end
      if (!fourth_in_hold_port_i) begin
        d_q <= op_fourth_i;
      end
    end
  end

  // multiplier pipeline: halves cleared by their section
  always_ff @(posedge clk_i) begin
    if (rst_i || upper_input_clear_port_i) begin
      mul_q[31:16] <= OPND_RST;
    end else if (slice_clk_en_i) begin
      mul_q[31:16] <= prod[31:16];
    end
    if (rst_i || lower_input_clear_port_i) begin
      mul_q[15:0] <= OPND_RST;
    end else if (slice_clk_en_i) begin
      mul_q[15:0] <= prod[15:0];
    end
  end

  // intermediate (result pipeline) register, lower clear
  always_ff @(posedge clk_i) begin
    if (rst_i || lower_input_clear_port_i) begin
      mid_q <= WORD_RST;
    end else if (slice_clk_en_i) begin
      mid_q <= mul_v;
    end
  end

  // upper accumulator with cascade flags
  always_ff @(posedge clk_i) begin
    if (rst_i || upper_acc_clear_port_i) begin
      acc_hi  <= OPND_RST;
      carry_q <= 1'b0;
      sign_q  <= 1'b0;
    end else if (slice_clk_en_i && !upper_acc_hold_port_i) begin
      acc_hi  <= next_hi;
      carry_q <= next_carry;
      sign_q  <= next_hi[15];
    end
  end

  // lower accumulator
  always_ff @(posedge clk_i) begin
    if (rst_i || lower_acc_clear_port_i) begin
      acc_lo <= OPND_RST;
    end else if (slice_clk_en_i && !lower_acc_hold_port_i) begin
      acc_lo <= next_lo;
    end
  end

  // ==========================================================
  // wishbone slave: one wait state, unmapped reads zero
  logic req;      // new access this cycle
  logic adr_cfg;  // configuration selected
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign adr_cfg = (wb_adr_i == ADR_W'(CFG_OFS));

  // acknowledge one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // configuration write with byte lanes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= CFG_RST;
    end else if (req && wb_we_i && adr_cfg) begin
      if (wb_sel_i[0]) begin
        cfg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        cfg[11:8] <= wb_dat_i[11:8];
      end
    end
  end

  // read data, registered with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= WORD_RST;
    end else if (req) begin
      case (wb_adr_i)
        ADR_W'(CFG_OFS):   wb_dat_o <= {20'h00000, cfg};
        ADR_W'(RES_OFS):   wb_dat_o <= result_o;
        ADR_W'(CHAIN_OFS): wb_dat_o <= {30'h0000_0000,
                                        chain_sign_out_o,
                                        chain_carry_out_o};
        default:           wb_dat_o <= WORD_RST;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking mas_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  bus_ack_a: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");

  upper_clear_a: assert property (
    upper_input_clear_port_i |=> (a_q == 16'h0000) && (c_q == 16'h0000)
      && (mul_q[31:16] == 16'h0000))
    else $error("upper clear missed a register");

  lower_clear_a: assert property (
    lower_input_clear_port_i |=> (b_q == 16'h0000) && (d_q == 16'h0000)
      && (mid_q == 32'h0000_0000))
    else $error("lower clear missed a register");

  operand_hold_a: assert property (
    (!upper_input_clear_port_i && first_in_hold_port_i) |=> $stable(a_q))
    else $error("held first operand changed");

  operand_load_a: assert property (
    (!upper_input_clear_port_i && slice_clk_en_i && !first_in_hold_port_i)
      |=> (a_q == $past(op_first_i)))
    else $error("first operand not loaded");

  clk_en_a: assert property (
    (!slice_clk_en_i && !upper_acc_clear_port_i && !lower_acc_clear_port_i
      && !lower_input_clear_port_i) |=> $stable(acc_hi) && $stable(acc_lo)
      && $stable(mid_q))
    else $error("register moved with enable low");

  acc_load_a: assert property (
    (slice_clk_en_i && !upper_acc_hold_port_i && !upper_acc_clear_port_i
      && upper_acc_load_port_i) |=> (acc_hi == $past(c_v)))
    else $error("upper load did not take third operand");

  acc_hold_a: assert property (
    (lower_acc_hold_port_i && !lower_acc_clear_port_i) |=> $stable(acc_lo))
    else $error("held lower accumulator changed");

  acc_clear_a: assert property (
    upper_acc_clear_port_i |=> (acc_hi == 16'h0000) && !carry_q)
    else $error("upper accumulator not cleared");

  split_mul_a: assert property (
    cfg[CFG_SPLIT_MUL] |-> (prod[15:0] == 16'(a_v[7:0] * b_v[7:0])))
    else $error("lower split product wrong");

  split_iso_a: assert property (
    (cfg[CFG_SPLIT_ACC] && !upper_acc_load_port_i)
      |-> (next_hi == sum_h[15:0]))
    else $error("upper half depends on lower half");

  upper_hold_a: assert property (
    (upper_acc_hold_port_i && !upper_acc_clear_port_i)
      |=> $stable(acc_hi) && $stable(carry_q))
    else $error("held upper accumulator changed");

  lower_load_a: assert property (
    (slice_clk_en_i && !lower_acc_hold_port_i && !lower_acc_clear_port_i
      && lower_acc_load_port_i) |=> (acc_lo == $past(c_v)))
    else $error("lower load did not take third operand");

  lower_acc_clear_a: assert property (
    lower_acc_clear_port_i |=> (acc_lo == 16'h0000))
    else $error("lower accumulator not cleared");

  joint_add_a: assert property (
    (!cfg[CFG_SPLIT_ACC] && !upper_add_sub_port_i && !upper_acc_load_port_i
      && !lower_acc_load_port_i)
      |-> ({next_hi, next_lo} == 32'(y_w + x_w + 32'(chain_carry_in_i))))
    else $error("joint adder lost the lower carry");

  split_sub_a: assert property (
    (cfg[CFG_SPLIT_ACC] && lower_add_sub_port_i && !lower_acc_load_port_i)
      |-> (next_lo == 16'(y_w[15:0] - x_w[15:0] - 16'(chain_carry_in_i))))
    else $error("lower split subtract wrong");

  cfg_write_a: assert property (
    (req && wb_we_i && adr_cfg && (wb_sel_i[1:0] == 2'h3))
      |=> (cfg == $past(wb_dat_i[CFG_W-1:0])))
    else $error("configuration write not stored");

endmodule : mas_slice
`default_nettype wire

// *** verification/mas_fabric.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// user fabric model: operands and controls for the slice
module mas_fabric (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // source select and directed bundle
  input  wire logic        rnd_i,
  input  wire logic [80:0] dir_i,
  // bundle towards the slice
  output var  logic [80:0] fab_o
);
  int          seed = 61421; // fixed seed, repeatable run
  logic [31:0] r;            // control draw
  logic [31:0] s;            // sign draw
  initial fab_o = '0;
  // one new bundle per edge, drawn or directed
  always @(posedge clk_i) begin
    if (rst_i) begin
      fab_o <= '0;                    // fabric idle in reset
    end else if (rnd_i) begin
      r = $random(seed);
      s = $random(seed);
      fab_o[31:0]  <= $random(seed);  // first, second operands
      fab_o[63:32] <= $random(seed);  // third, fourth operands
      fab_o[64]    <= |r[2:0];        // enable mostly high
      fab_o[68:65] <= r[6:3] & r[10:7];
      fab_o[70:69] <= r[12:11];       // input clears
      fab_o[71]    <= &r[14:13];      // upper hold
      fab_o[72]    <= &r[17:15];      // upper clear
      fab_o[73]    <= &r[20:18];      // upper load
      fab_o[74]    <= r[21];          // upper subtract
      fab_o[75]    <= &r[23:22];      // lower hold
      fab_o[76]    <= &r[26:24];      // lower clear
      fab_o[77]    <= &r[29:27];      // lower load
      fab_o[78]    <= r[30];          // lower subtract
      fab_o[79]    <= r[31];          // cascade carry in
      fab_o[80]    <= s[0];           // cascade sign in
    end else begin
      fab_o <= dir_i;                 // directed values
    end
  end
endmodule : mas_fabric
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench for the multiply-accumulate slice
module testbench;
  import mas_pkg::*;
  logic        clk_i = 1'b0; // 50 MHz clock
  logic        rst_i = 1'b1; // synchronous reset
  logic        cyc = 1'b0;   // bus cycle
  logic        stb = 1'b0;   // bus strobe
  logic        we = 1'b0;    // bus write
  logic [7:0]  adr = 8'h00;  // bus address
  logic [3:0]  sel = 4'h0;   // byte lanes
  logic [31:0] dat = '0;     // write data
  logic        rnd = 1'b0;   // fabric draws at random
  logic [80:0] dir = '0;     // directed bundle
  wire  [80:0] fab;          // bundle at the slice
  wire  [31:0] rd_o;         // read data
  wire         ack_o;        // acknowledge
  wire  [31:0] res_o;        // slice result
  wire         cy_o;         // cascade carry out
  wire         sg_o;         // cascade sign out
  int          mismatches = 0;
  int          compares = 0;
  logic [31:0] q;            // read-back word
  logic [31:0] exp_w;        // expected result
  logic [31:0] p;            // expected product
  logic [15:0] a16;          // directed first operand
  logic [15:0] b16;          // directed second operand
  logic [16:0] ecy;          // expected upper sum with carry
  logic        cv;           // carry expectation valid
  always #10 clk_i = ~clk_i;
  mas_slice i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rd_o), .wb_ack_o(ack_o),
    .slice_clk_en_i(fab[64]), .op_first_i(fab[15:0]),
    .op_second_i(fab[31:16]), .op_third_i(fab[47:32]),
    .op_fourth_i(fab[63:48]), .first_in_hold_port_i(fab[65]),
    .second_in_hold_port_i(fab[66]), .third_in_hold_port_i(fab[67]),
    .fourth_in_hold_port_i(fab[68]), .upper_input_clear_port_i(fab[69]),
    .lower_input_clear_port_i(fab[70]), .upper_acc_hold_port_i(fab[71]),
    .upper_acc_clear_port_i(fab[72]), .upper_acc_load_port_i(fab[73]),
    .upper_add_sub_port_i(fab[74]), .lower_acc_hold_port_i(fab[75]),
    .lower_acc_clear_port_i(fab[76]), .lower_acc_load_port_i(fab[77]),
    .lower_add_sub_port_i(fab[78]), .chain_carry_in_i(fab[79]),
    .chain_sign_in_i(fab[80]), .chain_carry_out_o(cy_o),
    .chain_sign_out_o(sg_o), .result_o(res_o));
  mas_fabric i_fab (.clk_i(clk_i), .rst_i(rst_i), .rnd_i(rnd),
    .dir_i(dir), .fab_o(fab));
  // ==========================================================
  // comparisons and closing
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: word %h, expected %h", $time, g, e);
    end
  endtask : chk_word
  task automatic chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: bit %b, expected %b", $time, g, e);
    end
  endtask : chk_bit
  task results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  // ==========================================================
  // one classic bus cycle, read data lands in q
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) chk_bit(ack_o, 1'b1);
  endtask : wb
  // wait for the edge where the slice sees a bundle bit
  task automatic wait_bit(input int i, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (fab[i] !== v && n < 20);
    if (n >= 20) chk_bit(fab[i], v);
  endtask : wait_bit
  // directed bundle: enabled, operands, optional clears
  function automatic logic [80:0] mk(input logic [15:0] a,
                                     input logic [15:0] b, input logic c);
    logic [80:0] v;
    v = '0;
    v[31:0] = {b, a};
    v[64] = 1'b1;
    {v[70:69], v[72], v[76]} = {4{c}};
    return v;
  endfunction : mk
  // accumulator after one edge with bypassed pipeline
  function automatic logic [31:0] nxt(input logic [31:0] a,
                                      input logic [80:0] v, input logic sp);
    logic [15:0] ph, pl, hi, lo;
    logic [31:0] s;
    ph = v[15:8] * v[31:24];
    pl = v[7:0] * v[23:16];
    s = v[74] ? a - v[15:0] * v[31:16] - v[79]
              : a + v[15:0] * v[31:16] + v[79];
    hi = v[74] ? a[31:16] - ph : a[31:16] + ph;
    lo = v[78] ? a[15:0] - pl - v[79] : a[15:0] + pl + v[79];
    if (!sp) {hi, lo} = s;
    if (v[72]) hi = 16'h0;
    else if (!v[64] || v[71]) hi = a[31:16];
    else if (v[73]) hi = v[47:32];
    if (v[76]) lo = 16'h0;
    else if (!v[64] || v[75]) lo = a[15:0];
    else if (v[77]) lo = v[47:32];
    return {hi, lo};
  endfunction : nxt
  // ==========================================================
  // watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, CFG_OFS, '0, 4'hf);
    chk_word(q, {20'h0, CFG_RST});
    wb(1'b1, CFG_OFS, '0, 4'hc);
    wb(1'b0, CFG_OFS, '0, 4'hf);
    chk_word(q, {20'h0, CFG_RST});
    wb(1'b1, RES_OFS, 32'hffff_ffff, 4'hf);
    wb(1'b0, RES_OFS, '0, 4'hf);
    chk_word(q, WORD_RST);
    wb(1'b0, 8'h40, '0, 4'hf);
    chk_word(q, 32'h0);
    $display("test bus finished");
    // product latency through all pipeline stages
    for (int k = 0; k < 2; k++) begin
      a16 = k ? 16'hffff : 16'h3a5c;
      b16 = k ? 16'hffff : 16'h0b17;
      p = a16 * b16;
      dir <= mk(a16, b16, 1'b1);
      wait_bit(72, 1'b1);
      repeat (2) @(posedge clk_i);
      dir <= mk(a16, b16, 1'b0);
      wait_bit(72, 1'b0);
      repeat (3) @(posedge clk_i);
      chk_word(res_o, 32'h0);
      @(posedge clk_i);
      chk_word(res_o, p);
      @(posedge clk_i);
      chk_word(res_o, p + p);
    end
    $display("test pipeline finished");
    // random traffic, joint then split halves
    for (int sp = 0; sp < 2; sp++) begin
      wb(1'b1, CFG_OFS, sp ? 32'hcc3 : 32'hcc0, 4'hf);
      wb(1'b0, CFG_OFS, '0, 4'hf);
      chk_word(q, sp ? 32'hcc3 : 32'hcc0);
      dir <= mk(16'h0, 16'h0, 1'b1);
      wait_bit(72, 1'b1);
      exp_w = '0;
      cv = 1'b0;
      rnd <= 1'b1;
      repeat (300) begin
        @(posedge clk_i);
        chk_word(res_o, exp_w);
        chk_bit(sg_o, exp_w[31]);
        if (cv) chk_bit(cy_o, ecy[16]);
        cv = sp && fab[64] && !fab[71] && !fab[72] && !fab[73];
        ecy = fab[74] ? exp_w[31:16] - fab[15:8] * fab[31:24]
                      : exp_w[31:16] + fab[15:8] * fab[31:24];
        exp_w = nxt(exp_w, fab, sp[0]);
      end
      rnd <= 1'b0;
      $display("test random %0d finished", sp);
    end
    results();
  end
endmodule : testbench
`default_nettype wire
